// *** hdl/sswc_pkg.sv ***
package sswc_pkg;
   // ==========================================================
   // Register offsets (printed offsets not all multiples of 4: index, byte = 4*index)
   localparam logic [15:0] SSWC_IDX_SUPPLY = 16'h00f9;
   localparam logic [15:0] SSWC_IDX_REF = 16'h2704;
   localparam logic [15:0] SSWC_IDX_TSEL = 16'h270a;
   localparam logic [15:0] SSWC_IDX_WTMR = 16'h2880;
   localparam logic [15:0] SSWC_IDX_WFLAG = 16'h28b1;
   localparam logic [15:0] SSWC_IDX_ARM = 16'h28b2;
   localparam logic [15:0] SSWC_IDX_WDOG = 16'h28b4;
   // Own registers: wake configuration with sleep control, and status
   localparam logic [15:0] SSWC_IDX_WCFG = 16'h2900;
   localparam logic [15:0] SSWC_IDX_STATUS = 16'h2901;
   localparam int SSWC_ADR_W = 18;
   // ==========================================================
   // Field positions
   localparam int SSWC_BIT_REF_OUT = 7;
   localparam int SSWC_BIT_REF_OFF = 6;
   localparam int SSWC_BIT_ARM = 5;
   localparam int SSWC_BIT_WDOG = 7;
   localparam int SSWC_BIT_WF_A = 2;
   localparam int SSWC_BIT_WF_B = 0;
   localparam int SSWC_BIT_TEMPERATURE_WAKE_FLAG = 6;
   localparam int SSWC_BIT_CFG_A = 0;
   localparam int SSWC_BIT_CFG_B = 1;
   localparam int SSWC_BIT_SLEEP = 2;
   localparam int SSWC_BIT_DISP = 3;
   localparam int SSWC_BIT_FLASH_BLK = 0;
   localparam int SSWC_BIT_PLL_FAST = 1;
   localparam int SSWC_BIT_EXPIRED = 2;
   localparam int SSWC_BIT_RUNNING = 3;
   // ==========================================================
   // Supply state codes
   localparam logic [2:0] SSWC_ST_OK = 3'h0;
   localparam logic [2:0] SSWC_ST_LOW = 3'h1;
   localparam logic [2:0] SSWC_ST_BAT = 3'h2;
   localparam logic [2:0] SSWC_ST_BAT_LOW = 3'h3;
   localparam logic [2:0] SSWC_ST_FAIL = 3'h5;
   // ==========================================================
   // Timing
   localparam int SSWC_CLK_HZ = 200000000;
   localparam int SSWC_SEC_S = 1;
   localparam int SSWC_SEC_CYC = SSWC_CLK_HZ * SSWC_SEC_S;
   localparam int SSWC_WD_W = 24;
endpackage

// *** hdl/sswc_top.sv ***
`timescale 1ns/10ps
module sswc_top #(
   parameter int SEC_CYCLES = sswc_pkg::SSWC_SEC_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [sswc_pkg::SSWC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Supply comparators (asynchronous)
   input wire logic analog_supply_good,
   input wire logic main_supply_good,
   input wire logic core_supply_good,
   input wire logic core_above_low_threshold,
   input wire logic core_trim_fuse,
   // Wake sources (debounced elsewhere, asynchronous)
   input wire logic wake_pin_a,
   input wire logic wake_pin_b,
   input wire logic temp_range_wake,
   // Analog and system controls
   output logic reference_to_pin,
   output logic reference_off,
   output logic flash_write_block,
   output logic pll_fast,
   output logic [2:0] remote_sensor_test_sel,
   output logic sleep_mode,
   output logic display_only_mode,
   output logic wake_timer_expired,
   output logic watchdog_restart
);

   // ==========================================================
   // Input synchronisers
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic pin_a_d_reg;
   logic pin_b_d_reg;
   logic temp_d_reg;

   // Two flops for every asynchronous input
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= {temp_range_wake, wake_pin_b, wake_pin_a, core_trim_fuse,
                       core_above_low_threshold, core_supply_good, main_supply_good, analog_supply_good};
         sync2_reg <= sync1_reg;
      end
   end

   wire a_ok = sync2_reg[0];
   wire m_ok = sync2_reg[1];
   wire c_ok = sync2_reg[2];
   wire c_hi = sync2_reg[3];
   wire fuse = sync2_reg[4];
   wire pin_a = sync2_reg[5];
   wire pin_b = sync2_reg[6];
   wire temp_w = sync2_reg[7];

   // ==========================================================
   // Supply state encoder
   logic [2:0] supply_state_code_reg;

   // Priority from healthiest down; only five codes exist
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         supply_state_code_reg <= sswc_pkg::SSWC_ST_FAIL;
      else if (a_ok && m_ok)
         supply_state_code_reg <= sswc_pkg::SSWC_ST_OK;
      else if (m_ok)
         supply_state_code_reg <= sswc_pkg::SSWC_ST_LOW;
      else if (c_ok && c_hi)
         supply_state_code_reg <= sswc_pkg::SSWC_ST_BAT;
      else if (c_hi)
         supply_state_code_reg <= sswc_pkg::SSWC_ST_BAT_LOW;
      // core failing, no other code possible
      else
         supply_state_code_reg <= sswc_pkg::SSWC_ST_FAIL;
   end

   // ==========================================================
   // Bus decode
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [15:0] idx = wb_adr_i[sswc_pkg::SSWC_ADR_W-1:2];
   wire wr = req && wb_we_i && wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];

   // ==========================================================
   // Control registers
   logic ref_out_reg;
   logic [2:0] tsel_reg;
   logic [7:0] wtmr_reg;
   logic arm_reg;
   logic cfg_a_reg;
   logic cfg_b_reg;

   // Software-written controls; read-only locations ignore writes
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ref_out_reg <= 1'b0;
         reference_off <= 1'b0;
         tsel_reg <= 3'h0;
         wtmr_reg <= 8'h00;
         arm_reg <= 1'b0;
         cfg_a_reg <= 1'b0;
         cfg_b_reg <= 1'b0;
         sleep_mode <= 1'b0;
         display_only_mode <= 1'b0;
      end
      else if (wr)
      begin
         // supply code and flag offsets are not decoded for writes
         unique case (idx)
            sswc_pkg::SSWC_IDX_REF:
            begin
               ref_out_reg <= wd[sswc_pkg::SSWC_BIT_REF_OUT];
               reference_off <= wd[sswc_pkg::SSWC_BIT_REF_OFF];
            end
            sswc_pkg::SSWC_IDX_TSEL: tsel_reg <= wd[2:0];
            sswc_pkg::SSWC_IDX_WTMR: wtmr_reg <= wd;
            sswc_pkg::SSWC_IDX_ARM: arm_reg <= wd[sswc_pkg::SSWC_BIT_ARM];
            sswc_pkg::SSWC_IDX_WCFG:
            begin
               cfg_a_reg <= wd[sswc_pkg::SSWC_BIT_CFG_A];
               cfg_b_reg <= wd[sswc_pkg::SSWC_BIT_CFG_B];
               sleep_mode <= wd[sswc_pkg::SSWC_BIT_SLEEP];
               display_only_mode <= wd[sswc_pkg::SSWC_BIT_DISP];
            end
            default:
            begin
            end
         endcase
      end
   end

   wire arm_write = wr && (idx == sswc_pkg::SSWC_IDX_ARM) && wd[sswc_pkg::SSWC_BIT_ARM];

   // ==========================================================
   // Analog and system outputs
   // Routing follows the values being written, so it never lags the disable bit
   wire ref_wr = wr && (idx == sswc_pkg::SSWC_IDX_REF);
   wire ref_out_next = ref_wr ? wd[sswc_pkg::SSWC_BIT_REF_OUT] : ref_out_reg;
   wire ref_off_next = ref_wr ? wd[sswc_pkg::SSWC_BIT_REF_OFF] : reference_off;

   // Registered so every output comes from a flop
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         reference_to_pin <= 1'b0;
         flash_write_block <= 1'b0;
         pll_fast <= 1'b1;
         remote_sensor_test_sel <= 3'h0;
      end
      else
      begin
         reference_to_pin <= ref_out_next && !ref_off_next;
         flash_write_block <= (supply_state_code_reg == sswc_pkg::SSWC_ST_BAT_LOW);
         // fast PLL dropped once, stays low until reset
         if ((supply_state_code_reg == sswc_pkg::SSWC_ST_BAT_LOW) && fuse)
            pll_fast <= 1'b0;
         remote_sensor_test_sel <= tsel_reg;
      end
   end

   // ==========================================================
   // Seconds timebase and wake timer
   logic [31:0] sec_cnt_reg;
   logic [8:0] wake_cnt_reg;
   logic wake_run_reg;
   wire sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));
   wire active = arm_reg && (sleep_mode || display_only_mode);

   // One-cycle enable per second while counting; restarts on arm
   always_ff @(posedge clk)
   begin
      if (!rst_b || arm_write || !active)
         sec_cnt_reg <= 32'h0;
      else if (sec_tick)
         sec_cnt_reg <= 32'h0;
      else
         sec_cnt_reg <= sec_cnt_reg + 32'h1;
   end

   // Count of seconds still to run, duration plus one
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wake_cnt_reg <= 9'h000;
         wake_run_reg <= 1'b0;
         wake_timer_expired <= 1'b0;
      end
      else if (arm_write)
      begin
         wake_cnt_reg <= {1'b0, wtmr_reg} + 9'h001;
         wake_run_reg <= 1'b1;
         wake_timer_expired <= 1'b0;
      end
      // only counts in sleep or display-only
      else if (wake_run_reg && active && sec_tick)
      begin
         wake_cnt_reg <= wake_cnt_reg - 9'h001;
         if (wake_cnt_reg == 9'h001)
         begin
            wake_run_reg <= 1'b0;
            wake_timer_expired <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Watchdog restart
   // one-cycle pulse on written one
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         watchdog_restart <= 1'b0;
      else
         watchdog_restart <= wr && (idx == sswc_pkg::SSWC_IDX_WDOG) && wd[sswc_pkg::SSWC_BIT_WDOG];
   end

   // ==========================================================
   // Wake flags
   logic wf_a_reg;
   logic wf_b_reg;
   logic wf_t_reg;

   // Edge history on synchronised copies only
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin_a_d_reg <= 1'b0;
         pin_b_d_reg <= 1'b0;
         temp_d_reg <= 1'b0;
      end
      else
      begin
         pin_a_d_reg <= pin_a;
         pin_b_d_reg <= pin_b;
         temp_d_reg <= temp_w;
      end
   end

   // Pin flags sticky until source unconfigured or reset, temperature flag until reset; no software clear
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wf_a_reg <= 1'b0;
         wf_b_reg <= 1'b0;
         wf_t_reg <= 1'b0;
      end
      else
      begin
         if (!cfg_a_reg)
            wf_a_reg <= 1'b0;
         else if (pin_a && !pin_a_d_reg)
            wf_a_reg <= 1'b1;
         if (!cfg_b_reg)
            wf_b_reg <= 1'b0;
         else if (pin_b && !pin_b_d_reg)
            wf_b_reg <= 1'b1;
         if (temp_w && !temp_d_reg)
            wf_t_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Read mux and acknowledge
   logic [7:0] rd;

   // Unmapped and write-only locations read zero
   always_comb
   begin
      rd = 8'h00;
      unique case (idx)
         sswc_pkg::SSWC_IDX_SUPPLY: rd = {5'h00, supply_state_code_reg};
         sswc_pkg::SSWC_IDX_REF: rd = {ref_out_reg, reference_off, 6'h00};
         sswc_pkg::SSWC_IDX_TSEL: rd = {5'h00, tsel_reg};
         sswc_pkg::SSWC_IDX_WTMR: rd = wtmr_reg;
         sswc_pkg::SSWC_IDX_WFLAG: rd = {1'b0, wf_t_reg, 3'h0, wf_a_reg, 1'b0, wf_b_reg};
         sswc_pkg::SSWC_IDX_ARM: rd = {2'h0, arm_reg, 5'h00};
         sswc_pkg::SSWC_IDX_WCFG: rd = {4'h0, display_only_mode, sleep_mode, cfg_b_reg, cfg_a_reg};
         sswc_pkg::SSWC_IDX_STATUS: rd = {4'h0, wake_run_reg, wake_timer_expired, pll_fast, flash_write_block};
         default: rd = 8'h00;
      endcase
   end

   // Single-cycle answer, dropped the cycle after
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h000000, rd} : 32'h0;
      end
   end

endmodule

// *** tb/sswc_properties.sv ***
`timescale 1ns/10ps
// ==========================================
// Port-level checks for the supply and wake block
module sswc_checker #(
   parameter int SEC_CYCLES = 10
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Controls
   input wire logic reference_to_pin,
   input wire logic reference_off,
   input wire logic pll_fast,
   input wire logic sleep_mode,
   input wire logic display_only_mode,
   input wire logic wake_timer_expired,
   input wire logic watchdog_restart
);
   // New request taken on this edge
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Guards on $past keep a short mid-run reset from firing them
   property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack is not one pulse");
   property p_idle_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_idle_dat: assert property (p_idle_dat) else $error("read data without ack");
   property p_ref_pin; reference_to_pin |-> !reference_off; endproperty
   a_ref_pin: assert property (p_ref_pin) else $error("reference on pin while off");
   property p_ref_off; !$stable(reference_off) && $past(rst_b) |->
      $past(wb_we_i && wb_adr_i == 18'h09c10) && reference_off == $past(wb_dat_i[6]); endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference off changed alone");
   property p_pll; $past(rst_b) |-> !$rose(pll_fast); endproperty
   a_pll: assert property (p_pll) else $error("fast pll came back");
   property p_wdog; watchdog_restart |->
      $past(wb_we_i && wb_adr_i == 18'h0a2d0 && wb_dat_i[7]) ##1 !watchdog_restart; endproperty
   a_wdog: assert property (p_wdog) else $error("bad watchdog restart pulse");
   property p_sleep; !$stable(sleep_mode) && $past(rst_b) |->
      $past(wb_we_i && wb_adr_i == 18'h0a400) && sleep_mode == $past(wb_dat_i[2]); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep changed alone");
   property p_expire; $rose(wake_timer_expired) |-> $past(sleep_mode || display_only_mode); endproperty
   a_expire: assert property (p_expire) else $error("timer expired while awake");
endmodule

bind sswc_top sswc_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reference_to_pin, .reference_off,
   .pll_fast, .sleep_mode, .display_only_mode, .wake_timer_expired, .watchdog_restart);

// *** tb/tb.sv ***
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the supply and wake block
module tb;
   localparam int SEC = 10;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic req = 1'h0;
   logic we = 1'h0;
   logic [17:0] adr = 18'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic a_ok = 1'h1, m_ok = 1'h1, c_ok = 1'h1, hi = 1'h1, fuse = 1'h0;
   logic pa = 1'h0, pb = 1'h0, tw = 1'h0;
   logic [31:0] rdat;
   logic ack, ref_pin, ref_off, fwb, pll, slp, disp, expd, wdr;
   logic [2:0] tsel;
   int n_errors = 0, n_compared = 0, n_wd = 0;

   sswc_top #(.SEC_CYCLES(SEC)) dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .analog_supply_good(a_ok), .main_supply_good(m_ok), .core_supply_good(c_ok),
      .core_above_low_threshold(hi), .core_trim_fuse(fuse), .wake_pin_a(pa), .wake_pin_b(pb),
      .temp_range_wake(tw), .reference_to_pin(ref_pin), .reference_off(ref_off),
      .flash_write_block(fwb), .pll_fast(pll), .remote_sensor_test_sel(tsel), .sleep_mode(slp),
      .display_only_mode(disp), .wake_timer_expired(expd), .watchdog_restart(wdr));

   initial forever #2.5 clk = ~clk;
   // Count restart pulses, so a doubled pulse shows too
   always @(posedge clk) if (wdr === 1'h1) n_wd++;

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         $display("FAIL %0t got %h want %h", $time, g, e);
         n_errors++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One classic cycle; waits for ack, never a fixed count
   task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'h1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'h1 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      q = rdat;
      req <= 1'h0;
      if (n == 20)
      begin
         $display("FAIL %0t bus timeout", $time);
         n_errors++;
         report_and_stop;
      end
   endtask
   task automatic rdchk(input logic [17:0] a, input logic [31:0] e);
      wb(1'h0, a, 8'h0);
      chk(q, e);
   endtask
   function automatic logic [2:0] code(input logic [3:0] v);
      if (v[3] && v[2]) return 3'h0;
      if (v[2]) return 3'h1;
      if (v[1] && v[0]) return 3'h2;
      if (v[0]) return 3'h3;
      return 3'h5;
   endfunction

   initial
   begin
      logic [3:0] v;
      logic [7:0] d;
      int n;
      void'($urandom(32'hd880a193));
      tick(6);
      rst_b <= 1'h1;
      // Reset values
      rdchk(18'h09c10, 0);
      rdchk(18'h0a200, 0);
      rdchk(18'h0a2c8, 0);
      chk(pll, 1);
      $display("reset values done");
      // Five defined codes, then random supply levels
      for (int i = 0; i < 21; i++)
      begin
         v = (i < 5) ? 4'hc >> i[2:0] : 4'($urandom);
         {a_ok, m_ok, c_ok, hi} <= v;
         tick(6);
         rdchk(18'h003e4, {29'h0, code(v)});
         chk(fwb, code(v) == 3'h3);
      end
      {a_ok, m_ok, c_ok, hi} <= 4'h1;
      fuse <= 1'h1;
      tick(8);
      chk(pll, 0);
      {a_ok, m_ok, c_ok, hi} <= 4'hf;
      $display("supply codes done");
      // Every reference bit pair
      for (int i = 0; i < 4; i++)
      begin
         wb(1'h1, 18'h09c10, {i[1:0], 6'h0});
         tick(2);
         chk(ref_pin, i == 2);
         chk(ref_off, i[0]);
         rdchk(18'h09c10, {24'h0, i[1:0], 6'h0});
      end
      // Read-only places, unmapped place, selector
      wb(1'h1, 18'h003e4, 8'hff);
      wb(1'h1, 18'h0a2c4, 8'hff);
      wb(1'h1, 18'h09c28, 8'h05);
      rdchk(18'h003e4, 0);
      rdchk(18'h0a2c4, 0);
      rdchk(18'h0a2fc, 0);
      chk(tsel, 5);
      $display("registers done");
      // Restart pulse only for a written one
      n = n_wd;
      wb(1'h1, 18'h0a2d0, 8'h80);
      wb(1'h1, 18'h0a2d0, 8'h7f);
      tick(3);
      chk(n_wd, n + 1);
      rdchk(18'h0a2d0, 0);
      // Pin flags, unconfigured then configured
      pa <= 1'h1;
      pb <= 1'h1;
      tick(6);
      rdchk(18'h0a2c4, 0);
      pa <= 1'h0;
      pb <= 1'h0;
      wb(1'h1, 18'h0a400, 8'h03);
      tick(6);
      pa <= 1'h1;
      tick(6);
      rdchk(18'h0a2c4, 32'h4);
      pb <= 1'h1;
      tick(6);
      rdchk(18'h0a2c4, 32'h5);
      wb(1'h1, 18'h0a400, 8'h00);
      tick(4);
      rdchk(18'h0a2c4, 0);
      $display("wake pins done");
      // Timer: zero, full scale and a random duration
      for (int i = 0; i < 3; i++)
      begin
         d = (i == 0) ? 8'h0 : (i == 1) ? 8'hff : 8'($urandom_range(1, 20));
         wb(1'h1, 18'h0a200, d);
         wb(1'h1, 18'h0a2c8, 8'h20);
         tick(SEC * (d + 1) + 4);
         chk(expd, 0);
         wb(1'h1, 18'h0a400, i[0] ? 8'h08 : 8'h04);
         chk(slp, !i[0]);
         chk(disp, i[0]);
         n = 0;
         while (expd !== 1'h1 && n < 3000)
         begin
            n++;
            @(posedge clk);
         end
         if (n == 3000)
         begin
            $display("FAIL %0t wake timer timeout", $time);
            n_errors++;
            report_and_stop;
         end
         chk(n >= SEC * (d + 1) - 3 && n <= SEC * (d + 1) + 4, 1);
         rdchk(18'h0a404, 32'h4);
         wb(1'h1, 18'h0a400, 8'h00);
      end
      $display("wake timer done");
      // Temperature wake
      tw <= 1'h1;
      tick(6);
      rdchk(18'h0a2c4, 32'h40);
      $display("temperature done");
      report_and_stop;
   end
endmodule
